/* File: core/tars_pkg.sv */
// Constants shared by the touch ADC result status block
package tars_pkg;
    localparam int unsigned ADDR_W          = 6;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned NUM_RESULTS     = 9;
    localparam int unsigned UPPER_W         = 4;
    localparam logic [5:0]  STATUS_ADDR     = 6'h01;
    localparam logic [5:0]  RSVD_ADDR       = 6'h02;
    localparam logic [15:0] RSVD_READ_VALUE = 16'hffff;
    localparam logic [15:0] STATUS_RESET    = 16'h0000;
    localparam logic [15:0] UNMAPPED_VALUE  = 16'h0000;
    localparam int unsigned UPPER_LSB       = 12;
    localparam int unsigned READY_BIT       = 11;
    // Result order: X, Y, Z1, Z2, battery A, battery B, aux, temp A, temp B
    localparam int unsigned FRESH_BIT [NUM_RESULTS] = '{10, 9, 8, 7, 6, 5, 4, 2, 1};
    localparam logic [1:0]  MODE_PEN        = 2'h0;
    localparam logic [1:0]  MODE_READY      = 2'h1;
    localparam logic        PIN_IDLE        = 1'h1;
endpackage

/* File: core/tars_flag.sv */
// Sticky flag cell: set by hardware, cleared by a completed read, set wins
`timescale 1ns/1ps
module tars_flag (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);
    logic next_flag;

    always_comb begin
        next_flag = o_flag;
        if (i_set) begin
            next_flag = 1'b1;
        end else if (i_clear) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flag <= 1'b0;
        end else begin
            o_flag <= next_flag;
        end
    end
endmodule

/* File: core/tars_top.sv */
// Conversion result status flags, status readback and data-ready pin
// Operation
// RULE1 - Summary ready flag sets when a conversion set ends, holds until all results read.
// RULE2 - X fresh flag sets on new X result, clears after it is fully read.
// RULE3 - Y fresh flag sets on new Y result, clears after it is fully read.
// RULE4 - Z1 fresh flag sets on new Z1 data, clears after it is fully read.
// RULE5 - Z2 fresh flag sets on new Z2 data, clears after it is fully read.
// RULE6 - Battery A fresh flag sets on new data, clears after full read.
// RULE7 - Battery B fresh flag sets on new data, clears after full read.
// RULE8 - Auxiliary fresh flag sets on new data, clears after full read.
// RULE9 - Temperature A fresh flag sets on new data, clears after full read.
// RULE10 - Temperature B fresh flag sets on new data, clears after full read.
// RULE11 - All status flags are read-only and zero after reset.
// RULE12 - Reserved status bits 3 and 0 always read as zero.
// RULE13 - Reserved register after status reads as all ones.
// RULE14 - In data-ready mode the pin is low while a finished set is unread.
// RULE15 - Host writes to status or reserved register change nothing.
`timescale 1ns/1ps
module tars_top
    import tars_pkg::*;
#(
    parameter int unsigned N_RES = NUM_RESULTS
) (
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    input  wire logic [N_RES-1:0]   i_result_stored,
    input  wire logic [N_RES-1:0]   i_result_read_done,
    input  wire logic               i_set_done,
    input  wire logic [1:0]         i_pin_mode,
    input  wire logic               i_pen_down,
    input  wire logic [UPPER_W-1:0] i_status_upper,
    input  wire logic [ADDR_W-1:0]  i_reg_addr,
    input  wire logic               i_reg_rd,
    input  wire logic               i_reg_wr,
    output logic [DATA_W-1:0]       o_reg_rdata,
    output logic                    o_reg_rvalid,
    output logic                    o_touch_or_ready_out_n
);
    logic [N_RES-1:0]  fresh;
    logic              set_complete_flag;
    logic              pen_pending;
    logic              next_set_complete_flag;
    logic              next_pen_pending;
    logic [DATA_W-1:0] next_reg_rdata;
    logic              next_reg_rvalid;
    logic              next_pin_n;
    logic [N_RES-1:0]  next_fresh;

    // Packs the flags and the upper field into the status word; bits 3 and 0 stay zero
    function automatic logic [DATA_W-1:0] status_word(input logic [N_RES-1:0]   f,
                                                      input logic               rdy,
                                                      input logic [UPPER_W-1:0] up);
        logic [DATA_W-1:0] w;
        w = STATUS_RESET;
        w[UPPER_LSB +: UPPER_W] = up;
        w[READY_BIT] = rdy;
        for (int k = 0; k < N_RES; k++) begin
            w[FRESH_BIT[k]] = f[k];
        end
        return w;
    endfunction

    // One sticky cell per result register
    generate
        for (genvar g = 0; g < N_RES; g++) begin : g_fresh
            tars_flag u_flag (
                .i_clk     (i_clk),
                .i_reset_n (i_reset_n),
                .i_set     (i_result_stored[g]),    // RULE2 RULE3 RULE4 RULE5 RULE6
                .i_clear   (i_result_read_done[g]), // RULE7 RULE8 RULE9 RULE10
                .o_flag    (fresh[g])
            );
        end
    endgenerate

    // Mirrors the cell equation so the summary flag sees this cycle's clears
    always_comb begin
        next_fresh = (fresh & ~i_result_read_done) | i_result_stored;
    end

    always_comb begin
        // Summary clears only once no result of the set is left unread
        next_set_complete_flag = i_set_done | (set_complete_flag & (|next_fresh)); // RULE1
        next_pen_pending = pen_pending;
        if (i_pen_down) begin
            next_pen_pending = 1'b1;
        end else if (i_set_done) begin
            next_pen_pending = 1'b0;
        end
    end

    always_comb begin
        case (i_pin_mode)
            MODE_PEN: begin
                next_pin_n = ~i_pen_down;
            end
            MODE_READY: begin
                next_pin_n = ~set_complete_flag; // RULE14
            end
            default: begin
                next_pin_n = ~pen_pending;
            end
        endcase
    end

    // Writes are not decoded at all, so no flag can be disturbed by one
    always_comb begin
        next_reg_rdata  = o_reg_rdata;
        next_reg_rvalid = i_reg_rd; // RULE15
        if (i_reg_rd) begin
            case (i_reg_addr)
                STATUS_ADDR: begin
                    next_reg_rdata = status_word(fresh, set_complete_flag, i_status_upper); // RULE12
                end
                RSVD_ADDR: begin
                    next_reg_rdata = RSVD_READ_VALUE; // RULE13
                end
                default: begin
                    next_reg_rdata = UNMAPPED_VALUE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            set_complete_flag      <= 1'b0; // RULE11
            pen_pending            <= 1'b0;
            o_reg_rdata            <= STATUS_RESET;
            o_reg_rvalid           <= 1'b0;
            o_touch_or_ready_out_n <= PIN_IDLE;
        end else begin
            set_complete_flag      <= next_set_complete_flag;
            pen_pending            <= next_pen_pending;
            o_reg_rdata            <= next_reg_rdata;
            o_reg_rvalid           <= next_reg_rvalid;
            o_touch_or_ready_out_n <= next_pin_n;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_set_finishes;
        i_set_done ##1 set_complete_flag;
    endsequence

    sequence s_ready_mode_held;
        (i_pin_mode == MODE_READY) [*2];
    endsequence

    property p_ready_sets;
        i_set_done |-> s_set_finishes;
    endproperty
    a_ready_sets: assert property (p_ready_sets) // RULE1
        else $error("summary flag did not set after set done");

    property p_ready_falls_only_when_read;
        $fell(set_complete_flag) |-> (fresh == '0) && !$past(i_set_done);
    endproperty
    a_ready_falls_only_when_read: assert property (p_ready_falls_only_when_read) // RULE1
        else $error("summary flag cleared with results unread");

    generate
        for (genvar a = 0; a < N_RES; a++) begin : g_chk
            property p_fresh_sets;
                i_result_stored[a] |=> fresh[a];
            endproperty
            a_fresh_sets: assert property (p_fresh_sets) // RULE2 RULE3 RULE4 RULE5 RULE6
                else $error("fresh flag did not set on new result");

            property p_fresh_holds;
                fresh[a] && !i_result_read_done[a] |=> fresh[a];
            endproperty
            a_fresh_holds: assert property (p_fresh_holds) // RULE7 RULE8 RULE9 RULE10
                else $error("fresh flag dropped before its result was read");

            property p_fresh_clears;
                fresh[a] && i_result_read_done[a] && !i_result_stored[a] |=> !fresh[a];
            endproperty
            a_fresh_clears: assert property (p_fresh_clears) // RULE2
                else $error("fresh flag not cleared after complete read");
        end
    endgenerate

    property p_status_read;
        i_reg_rd && (i_reg_addr == STATUS_ADDR) |=> o_reg_rvalid
            && (o_reg_rdata == status_word($past(fresh), $past(set_complete_flag),
                                           $past(i_status_upper)));
    endproperty
    a_status_read: assert property (p_status_read) // RULE11
        else $error("status read returned wrong word");

    property p_reserved_bits_zero;
        i_reg_rd && (i_reg_addr == STATUS_ADDR) |=> !o_reg_rdata[3] && !o_reg_rdata[0];
    endproperty
    a_reserved_bits_zero: assert property (p_reserved_bits_zero) // RULE12
        else $error("reserved status bit read as one");

    property p_rsvd_reg;
        i_reg_rd && (i_reg_addr == RSVD_ADDR) |=> o_reg_rvalid && (o_reg_rdata == RSVD_READ_VALUE);
    endproperty
    a_rsvd_reg: assert property (p_rsvd_reg) // RULE13
        else $error("reserved register did not read all ones");

    // Pin is registered, so it shows the summary seen one edge earlier
    property p_pin_ready;
        s_ready_mode_held and (set_complete_flag ##1 1'b1) |-> !o_touch_or_ready_out_n;
    endproperty
    a_pin_ready: assert property (p_pin_ready) // RULE14
        else $error("data-ready pin not low with unread set");

    // The summary may still drop by itself when its set left nothing unread
    property p_write_ignored;
        i_reg_wr && (i_result_stored == '0) && (i_result_read_done == '0) && !i_set_done
            |=> $stable(fresh)
            && (set_complete_flag == ($past(set_complete_flag) && (|$past(fresh))));
    endproperty
    a_write_ignored: assert property (p_write_ignored) // RULE15
        else $error("host write changed a status flag");
endmodule

/* File: test/tars_host_model.sv */
// Host side: finishes reading a result register promptly or after a stall
`timescale 1ns/1ps
module tars_host_model
    import tars_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic [NUM_RESULTS-1:0] i_req,
    input  wire logic                   i_slow,
    output logic      [NUM_RESULTS-1:0] o_read_done
);
    logic [1:0]             wait_cnt [NUM_RESULTS];
    logic [NUM_RESULTS-1:0] busy;
    // A stalled read keeps the flag up longer, so clearing is not tied to the request edge
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int k = 0; k < NUM_RESULTS; k++) begin
                busy[k]        <= 1'b0;
                wait_cnt[k]    <= 2'h0;
                o_read_done[k] <= 1'b0;
            end
        end else begin
            for (int k = 0; k < NUM_RESULTS; k++) begin
                o_read_done[k] <= 1'b0;
                if (busy[k]) begin
                    if (wait_cnt[k] == 2'h0) begin
                        o_read_done[k] <= 1'b1;
                        busy[k]        <= 1'b0;
                    end else begin
                        wait_cnt[k] <= wait_cnt[k] - 2'h1;
                    end
                end else if (i_req[k]) begin
                    busy[k]     <= 1'b1;
                    wait_cnt[k] <= i_slow ? 2'h3 : 2'h0;
                end
            end
        end
    end
endmodule

/* File: test/touch_adc_result_status_test.sv */
// Self-checking bench for the result status flags, readback and pin
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module touch_adc_result_status_test;
    import tars_pkg::*;
    logic i_clk, i_reset_n, i_set_done, i_pen_down, i_reg_rd, i_reg_wr, host_slow;
    logic [NUM_RESULTS-1:0] i_result_stored, i_result_read_done, host_req, fresh;
    logic [1:0]             i_pin_mode;
    logic [UPPER_W-1:0]     i_status_upper;
    logic [ADDR_W-1:0]      i_reg_addr;
    logic [DATA_W-1:0]      o_reg_rdata;
    logic                   o_reg_rvalid, o_touch_or_ready_out_n, sum, latch;
    logic [15:0]            exp_q [$];
    logic [15:0]            exp_w;
    logic [31:0]            seed, r;
    int                     n_fail, cmp_count;
    tars_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_result_stored(i_result_stored),
        .i_result_read_done(i_result_read_done), .i_set_done(i_set_done),
        .i_pin_mode(i_pin_mode), .i_pen_down(i_pen_down), .i_status_upper(i_status_upper),
        .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .o_touch_or_ready_out_n(o_touch_or_ready_out_n));
    tars_host_model host (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(host_req),
        .i_slow(host_slow), .o_read_done(i_result_read_done));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [15:0] st_word(logic [UPPER_W-1:0] up);
        logic [15:0] w;
        w = STATUS_RESET;
        w[15:12] = up;
        w[READY_BIT] = sum;
        for (int k = 0; k < NUM_RESULTS; k++) w[FRESH_BIT[k]] = fresh[k];
        return w;
    endfunction
    task automatic step(input logic [8:0] st, input logic [8:0] rq, input logic sd,
                        input logic rd, input logic [5:0] ad);
        logic [8:0] rdd;
        logic [8:0] nf;
        logic       p_exp;
        r = $random(seed);
        {i_status_upper, host_slow, i_reg_wr, i_pen_down} = r[6:0];
        {i_result_stored, host_req, i_set_done, i_reg_rd, i_reg_addr} = {st, rq, sd, rd, ad};
        rdd = i_result_read_done;
        // Writes are strobed at random and must leave the expected words untouched
        if (rd) exp_q.push_back(ad == STATUS_ADDR ? st_word(i_status_upper) :
                                ad == RSVD_ADDR ? RSVD_READ_VALUE : UNMAPPED_VALUE);
        p_exp = i_pin_mode == MODE_PEN ? ~i_pen_down : i_pin_mode == MODE_READY ? ~sum : ~latch;
        @(posedge i_clk);
        #1;
        `CHK("pin", p_exp, o_touch_or_ready_out_n)
        nf = (fresh & ~rdd) | st;
        sum = sd | (sum & (|nf));
        latch = i_pen_down | (latch & ~sd);
        fresh = nf;
    endtask
    task automatic do_reset();
        i_reset_n = 1'b0;
        {fresh, sum, latch} = '0;
        repeat (2) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
    endtask
    // Looked at mid-cycle, where the registered answer has settled
    always @(negedge i_clk) begin
        if (o_reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("rvalid", 1'b0, o_reg_rvalid)
            end else begin
                exp_w = exp_q.pop_front();
                `CHK("rdata", exp_w, o_reg_rdata)
            end
        end
    end
    initial begin
        #80000;
        n_fail++;
        conclude();
    end
    initial begin
        seed = 32'h3796;
        {i_result_stored, host_req, i_set_done, i_pen_down, i_reg_rd, i_reg_wr} = '0;
        {host_slow, i_status_upper, i_reg_addr, n_fail, cmp_count} = '0;
        i_pin_mode = MODE_READY;
        #1;
        do_reset();
        step(9'h0, 9'h0, 1'b0, 1'b1, STATUS_ADDR);
        step(9'h0, 9'h0, 1'b0, 1'b1, RSVD_ADDR);
        step(9'h0, 9'h0, 1'b0, 1'b1, 6'h00);
        step(9'h0, 9'h0, 1'b0, 1'b1, 6'h3f);
        for (int k = 0; k < NUM_RESULTS; k++) begin
            step(9'(1 << k), 9'h0, k == 8, 1'b1, STATUS_ADDR);
            step(9'h0, 9'h0, 1'b0, 1'b1, STATUS_ADDR);
        end
        for (int k = 0; k < NUM_RESULTS; k++) begin
            step(9'h0, 9'(1 << k), 1'b0, 1'b1, STATUS_ADDR);
            repeat (5) step(9'h0, 9'h0, 1'b0, 1'b1, STATUS_ADDR);
        end
        for (int m = 0; m < 4; m++) begin
            i_pin_mode = 2'(m);
            repeat (100) begin
                r = $random(seed);
                step(9'(r) & 9'(r >> 9) & 9'(r >> 18), 9'($random(seed)) & 9'(r >> 5),
                     r[29:27] == 3'h0, r[30], r[31] ? STATUS_ADDR : 6'(r >> 12));
            end
            step(9'h0, 9'h0, 1'b0, 1'b0, STATUS_ADDR);
            step(9'h0, 9'h0, 1'b0, 1'b0, STATUS_ADDR);
            if (m == 2) do_reset();
        end
        step(9'h0, 9'h0, 1'b0, 1'b1, STATUS_ADDR);
        repeat (3) step(9'h0, 9'h0, 1'b0, 1'b0, STATUS_ADDR);
        `CHK("queue", 0, exp_q.size())
        conclude();
    end
endmodule
